// *** logic/chgctl_pkg.sv ***
// shared constants and types of the charger control block
`default_nettype none
package chgctl_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h1b;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // control register fields
  localparam int CTL_START = 7;
  localparam int CTL_ADC_EN = 6;
  localparam int CTL_ADC_PERIODIC = 5;
  localparam int CTL_CH_VBAT = 4;
  localparam int CTL_CH_TEMP = 3;
  localparam int CTL_CH_AUX1 = 2;
  localparam int CTL_CH_AUX2 = 1;
  localparam int CTL_IRQ = 0;
  // status register fields
  localparam int ST_VEXT = 7;
  localparam int ST_BATT_ERR = 6;
  localparam int ST_TEMP_BAD = 5;
  localparam int ST_CURRENT_TERMINATION_DONE = 4;
  localparam int ST_NO_CHARGE_DETECTED = 3;
  localparam int ST_PRECHG = 2;
  localparam int ST_CONSTANT_CURRENT_TIMEOUT = 1;
  localparam int ST_TOTAL_CHARGE_TIMEOUT = 0;
  // termination ratio code 0..4 means 10%..50%
  localparam logic [2:0] TERM_RATIO_MAX = 3'h4;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_SECOND = 1_000_000_000;
  localparam int SECOND_CYCLES_DEFAULT = NS_PER_SECOND / CLK_PERIOD_NS;
  localparam logic [15:0] WAKE_TIME_S = 16'h0008;
  localparam logic [15:0] SECS_ZERO = 16'h0000;
  typedef enum logic [5:0] {
    CHGCTL_IDLE = 6'b000001,
    CHGCTL_WAKE = 6'b000010,
    CHGCTL_NO_CHARGE_DETECTED_HOLD = 6'b000100,
    CHGCTL_PRECHARGE = 6'b001000,
    CHGCTL_CONST_CURRENT = 6'b010000,
    CHGCTL_CONST_VOLTAGE = 6'b100000
  } chgctl_state_t;
endpackage
`default_nettype wire

// *** logic/chgctl_tmr_if.sv ***
// carrier between the sequencer and its seconds timer
`default_nettype none
interface chgctl_tmr_if;
  logic clr_phase;
  logic clr_total;
  logic [15:0] phase_secs;
  logic [15:0] total_secs;
  modport ctrl(output clr_phase, output clr_total, input phase_secs, input total_secs);
  modport tmr(input clr_phase, input clr_total, output phase_secs, output total_secs);
endinterface
`default_nettype wire

// *** logic/chgctl_timer.sv ***
// one-second prescaler with phase and total second counters
`default_nettype none
module chgctl_timer import chgctl_pkg::*; #(
  parameter int SECOND_CYCLES = SECOND_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  chgctl_tmr_if.tmr tmr
);
  typedef struct packed {
    logic [27:0] prescale;
    logic [15:0] phase;
    logic [15:0] total;
  } chgctl_tmr_state_t;

  localparam logic [27:0] LAST_CYCLE = 28'(SECOND_CYCLES - 1);

  chgctl_tmr_state_t r;
  chgctl_tmr_state_t next_r;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  always_comb begin
    next_r = r;
    if (r.prescale == LAST_CYCLE) begin
      next_r.prescale = 28'h0000000;
      next_r.phase = sat_inc(r.phase);
      next_r.total = sat_inc(r.total);
    end else begin
      next_r.prescale = r.prescale + 28'h0000001;
    end
    // phase restart also realigns the second boundary
    if (tmr.clr_phase) begin
      next_r.prescale = 28'h0000000;
      next_r.phase = SECS_ZERO;
    end
    if (tmr.clr_total) begin
      next_r.total = SECS_ZERO;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tmr.phase_secs = r.phase;
  assign tmr.total_secs = r.total;
endmodule
`default_nettype wire

// *** logic/chgctl_top.sv ***
// charger sequencer with its control and status registers
// How it works
// - writing one to charge_start begins charging; zero keeps the charger idle.
// - control bit 6 enables the converter.
// - control bit 5 picks single (0) or periodic (1) conversion.
// - control bits 4..1 include battery, temperature, aux1, aux2 channels.
// - a finished charge clears control bits 7 down to 1.
// - while charge_start is high the converter runs enabled and periodic.
// - charging always includes the battery voltage channel.
// - charging needs no software channel enable for temperature; aux channels still need theirs.
// - status register bits 7..0 report input, errors, phases and timeouts.
// - supply comes from the adapter when present, else from the battery.
// - supply divider follows the 4.1 V or 4.2 V level software picks.
// - adapter present drives the adapter gate high, charger and battery gates low.
// - a charge starts with pack wake-up; precharge follows a good wake-up.
// - precharge to 3.2 V within its limit, then fast charge.
// - constant current until regulation voltage, then constant voltage.
// - constant voltage ends when current falls below termination level.
// - termination level selectable from 10% to 50% of full current.
// - control bit 0 mirrors the interrupt; host clears it, device for temperature.
// - interrupt on adapter range change, charge errors, temperature, completion.
// - constant current timeout clears charge_start, flags error, interrupts.
// - after 8 s wake-up a battery above 4.3 V sets no_charge_detected.
`default_nettype none
module chgctl_top import chgctl_pkg::*; #(
  parameter int SECOND_CYCLES = SECOND_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic adapter_in_range,
  input wire logic batt_at_precharge_level,
  input wire logic batt_at_regulation,
  input wire logic current_below_term,
  input wire logic batt_above_nocharge_level,
  input wire logic batt_voltage_fault,
  input wire logic temp_out_of_range_in,
  input wire logic supply_level_42v,
  input wire logic [2:0] term_ratio_code,
  input wire logic [15:0] precharge_limit_s,
  input wire logic [15:0] cc_limit_s,
  input wire logic [15:0] total_limit_s,
  output logic adc_enable,
  output logic adc_periodic,
  output logic battery_voltage_channel_enable,
  output logic temperature_channel_enable,
  output logic aux_input1_enable,
  output logic aux_input2_enable,
  output logic charge_current_on,
  output logic precharge_mode,
  output logic const_voltage_mode,
  output logic [2:0] term_level_select,
  output logic charger_gate,
  output logic adapter_path_gate,
  output logic battery_path_gate,
  output logic supply_divider_setting,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctl;
    logic battery_error;
    logic temperature_out_of_range;
    logic current_termination_done;
    logic no_charge_detected;
    logic constant_current_timeout;
    logic total_charge_timeout;
    logic irq_from_temp;
    logic vext;
    chgctl_state_t state;
    logic [7:0] rdata;
    logic adc_en;
    logic adc_per;
    logic [3:0] adc_ch;
    logic chg_on;
    logic pre_mode;
    logic cv_mode;
    logic [2:0] term_sel;
    logic chg_gate;
    logic adp_gate;
    logic bat_gate;
    logic div_sel;
    logic clr_phase;
    logic clr_total;
  } chgctl_core_t;

  chgctl_core_t r;
  chgctl_core_t next_r;
  chgctl_tmr_if tmr_bus();

  logic charging;
  logic finish;
  logic irq_event;
  logic temp_rise;
  logic temp_fall;
  logic [7:0] status_word;
  // timer counts as the sequencer may use them
  logic [15:0] phase_now;
  logic [15:0] total_now;

  chgctl_timer #(
    .SECOND_CYCLES(SECOND_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tmr(tmr_bus.tmr)
  );

  // limit of zero disables the timeout
  function automatic logic timed_out(input logic [15:0] secs, input logic [15:0] limit);
    return (limit != SECS_ZERO) && (secs >= limit);
  endfunction

  function automatic logic [2:0] clamp_ratio(input logic [2:0] code);
    return (code > TERM_RATIO_MAX) ? TERM_RATIO_MAX : code;
  endfunction

  always_comb begin
    next_r = r;
    finish = 1'b0;
    irq_event = 1'b0;
    next_r.clr_phase = 1'b0;
    next_r.clr_total = 1'b0;
    // a clear still in flight reads as zero, never a stale count
    phase_now = r.clr_phase ? SECS_ZERO : tmr_bus.phase_secs;
    total_now = r.clr_total ? SECS_ZERO : tmr_bus.total_secs;
    status_word = 8'h00;
    status_word[ST_VEXT] = r.vext;
    status_word[ST_BATT_ERR] = r.battery_error;
    status_word[ST_TEMP_BAD] = r.temperature_out_of_range;
    status_word[ST_CURRENT_TERMINATION_DONE] = r.current_termination_done;
    status_word[ST_NO_CHARGE_DETECTED] = r.no_charge_detected;
    status_word[ST_PRECHG] = (r.state == CHGCTL_PRECHARGE);
    status_word[ST_CONSTANT_CURRENT_TIMEOUT] = r.constant_current_timeout;
    status_word[ST_TOTAL_CHARGE_TIMEOUT] = r.total_charge_timeout;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONTROL: next_r.rdata = r.ctl;
        ADDR_STATUS: next_r.rdata = status_word;
        default: next_r.rdata = UNMAPPED_READ;
      endcase
    end
    // host write; bit 0 only accepts a clear
    if (reg_wr && (reg_addr == ADDR_CONTROL)) begin
      next_r.ctl[7:1] = reg_wdata[7:1];
      if (!reg_wdata[CTL_IRQ]) begin
        next_r.ctl[CTL_IRQ] = 1'b0;
        next_r.irq_from_temp = 1'b0;
      end
    end
    next_r.vext = adapter_in_range;
    if (adapter_in_range != r.vext) begin
      irq_event = 1'b1;
    end
    charging = (r.state != CHGCTL_IDLE);
    temp_rise = charging && temp_out_of_range_in && !r.temperature_out_of_range;
    temp_fall = r.temperature_out_of_range && !(charging && temp_out_of_range_in);
    next_r.temperature_out_of_range = charging && temp_out_of_range_in;
    case (r.state)
      CHGCTL_IDLE: begin
        if (next_r.ctl[CTL_START]) begin
          next_r.battery_error = 1'b0;
          next_r.current_termination_done = 1'b0;
          next_r.no_charge_detected = 1'b0;
          next_r.constant_current_timeout = 1'b0;
          next_r.total_charge_timeout = 1'b0;
          next_r.clr_phase = 1'b1;
          next_r.clr_total = 1'b1;
          next_r.state = CHGCTL_WAKE;
        end
      end
      CHGCTL_WAKE: begin
        if (!next_r.ctl[CTL_START]) begin
          next_r.state = CHGCTL_IDLE;
        end else if (phase_now >= WAKE_TIME_S) begin
          if (batt_above_nocharge_level) begin
            next_r.no_charge_detected = 1'b1;
            next_r.state = CHGCTL_NO_CHARGE_DETECTED_HOLD;
          end else if (batt_voltage_fault) begin
            next_r.battery_error = 1'b1;
            finish = 1'b1;
          end else begin
            next_r.clr_phase = 1'b1;
            next_r.state = CHGCTL_PRECHARGE;
          end
        end
      end
      CHGCTL_NO_CHARGE_DETECTED_HOLD: begin
        // wait for host to drop start
        if (!next_r.ctl[CTL_START]) begin
          next_r.state = CHGCTL_IDLE;
        end
      end
      CHGCTL_PRECHARGE: begin
        if (!next_r.ctl[CTL_START]) begin
          next_r.state = CHGCTL_IDLE;
        end else if (batt_voltage_fault) begin
          next_r.battery_error = 1'b1;
          finish = 1'b1;
        end else if (!temp_out_of_range_in) begin
          if (batt_at_precharge_level) begin
            next_r.clr_phase = 1'b1;
            next_r.clr_total = 1'b1;
            next_r.state = CHGCTL_CONST_CURRENT;
          end else if (timed_out(phase_now, precharge_limit_s)) begin
            next_r.battery_error = 1'b1;
            finish = 1'b1;
          end
        end
      end
      CHGCTL_CONST_CURRENT: begin
        if (!next_r.ctl[CTL_START]) begin
          next_r.state = CHGCTL_IDLE;
        end else if (batt_voltage_fault) begin
          next_r.battery_error = 1'b1;
          finish = 1'b1;
        end else if (!temp_out_of_range_in) begin
          if (batt_at_regulation) begin
            next_r.clr_phase = 1'b1;
            next_r.state = CHGCTL_CONST_VOLTAGE;
          end else if (timed_out(phase_now, cc_limit_s)) begin
            next_r.constant_current_timeout = 1'b1;
            next_r.battery_error = 1'b1;
            finish = 1'b1;
          end
        end
      end
      CHGCTL_CONST_VOLTAGE: begin
        // total timer runs from fast charge entry
        if (!next_r.ctl[CTL_START]) begin
          next_r.state = CHGCTL_IDLE;
        end else if (batt_voltage_fault) begin
          next_r.battery_error = 1'b1;
          finish = 1'b1;
        end else if (!temp_out_of_range_in) begin
          if (current_below_term) begin
            next_r.current_termination_done = 1'b1;
            finish = 1'b1;
          end else if (timed_out(total_now, total_limit_s)) begin
            next_r.total_charge_timeout = 1'b1;
            finish = 1'b1;
          end
        end
      end
      default: begin
        next_r.state = CHGCTL_IDLE;
      end
    endcase
    if (finish) begin
      next_r.ctl[7:1] = 7'h00;
      next_r.state = CHGCTL_IDLE;
      irq_event = 1'b1;
    end
    if (temp_fall && r.irq_from_temp && !irq_event) begin
      next_r.ctl[CTL_IRQ] = 1'b0;
      next_r.irq_from_temp = 1'b0;
    end
    // raise interrupt, set wins over clear
    if (irq_event || temp_rise) begin
      next_r.ctl[CTL_IRQ] = 1'b1;
      next_r.irq_from_temp = temp_rise && !irq_event;
    end
    next_r.adc_en = next_r.ctl[CTL_ADC_EN] || next_r.ctl[CTL_START];
    next_r.adc_per = next_r.ctl[CTL_ADC_PERIODIC] || next_r.ctl[CTL_START];
    next_r.adc_ch[3] = next_r.ctl[CTL_CH_VBAT] || next_r.ctl[CTL_START];
    // temperature sensing needs no software enable while charge_start is high
    next_r.adc_ch[2] = next_r.ctl[CTL_CH_TEMP] || next_r.ctl[CTL_START];
    next_r.adc_ch[1] = next_r.ctl[CTL_CH_AUX1];
    next_r.adc_ch[0] = next_r.ctl[CTL_CH_AUX2];
    // charge current paused while temperature is bad
    next_r.chg_on = !temp_out_of_range_in && (next_r.state == CHGCTL_PRECHARGE ||
                    next_r.state == CHGCTL_CONST_CURRENT || next_r.state == CHGCTL_CONST_VOLTAGE);
    next_r.pre_mode = (next_r.state == CHGCTL_PRECHARGE);
    next_r.cv_mode = (next_r.state == CHGCTL_CONST_VOLTAGE);
    next_r.term_sel = clamp_ratio(term_ratio_code);
    next_r.chg_gate = !adapter_in_range;
    next_r.adp_gate = adapter_in_range;
    next_r.bat_gate = !adapter_in_range;
    next_r.div_sel = supply_level_42v;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
      r.ctl <= CONTROL_RESET;
      r.state <= CHGCTL_IDLE;
      r.chg_gate <= 1'b1;
      r.bat_gate <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign tmr_bus.clr_phase = r.clr_phase;
  assign tmr_bus.clr_total = r.clr_total;

  assign reg_rdata = r.rdata;
  assign adc_enable = r.adc_en;
  assign adc_periodic = r.adc_per;
  assign battery_voltage_channel_enable = r.adc_ch[3];
  assign temperature_channel_enable = r.adc_ch[2];
  assign aux_input1_enable = r.adc_ch[1];
  assign aux_input2_enable = r.adc_ch[0];
  assign charge_current_on = r.chg_on;
  assign precharge_mode = r.pre_mode;
  assign const_voltage_mode = r.cv_mode;
  assign term_level_select = r.term_sel;
  assign charger_gate = r.chg_gate;
  assign adapter_path_gate = r.adp_gate;
  assign battery_path_gate = r.bat_gate;
  assign supply_divider_setting = r.div_sel;
  assign irq = r.ctl[CTL_IRQ];
endmodule
`default_nettype wire

// *** dv/chgctl_chk.sv ***
// assertion checker on the charger control top ports
`default_nettype none
module chgctl_chk import chgctl_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic adapter_in_range,
  input wire logic batt_at_precharge_level,
  input wire logic batt_at_regulation,
  input wire logic current_below_term,
  input wire logic batt_voltage_fault,
  input wire logic temp_out_of_range_in,
  input wire logic supply_level_42v,
  input wire logic [2:0] term_ratio_code,
  input wire logic adc_enable,
  input wire logic adc_periodic,
  input wire logic battery_voltage_channel_enable,
  input wire logic charge_current_on,
  input wire logic precharge_mode,
  input wire logic const_voltage_mode,
  input wire logic [2:0] term_level_select,
  input wire logic charger_gate,
  input wire logic adapter_path_gate,
  input wire logic battery_path_gate,
  input wire logic supply_divider_setting,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence quiet_s; !temp_out_of_range_in && !batt_voltage_fault && !reg_wr; endsequence
  sequence pre_done_s; precharge_mode && batt_at_precharge_level ##0 quiet_s; endsequence
  sequence cc_done_s; charge_current_on && !precharge_mode && !const_voltage_mode && batt_at_regulation ##0 quiet_s;
  endsequence
  sequence cv_done_s; const_voltage_mode && current_below_term ##0 quiet_s; endsequence
  gates_follow_a: assert property (
    !$past(sys_rst) |-> adapter_path_gate == $past(adapter_in_range) && battery_path_gate != adapter_path_gate
      && charger_gate == battery_path_gate) else $error("power path gates do not follow adapter");
  divider_follows_a: assert property (
    !$past(sys_rst) |-> supply_divider_setting == $past(supply_level_42v)) else $error("divider setting wrong");
  term_clamp_a: assert property (
    !$past(sys_rst) |-> term_level_select == (($past(term_ratio_code) > TERM_RATIO_MAX) ? TERM_RATIO_MAX
      : $past(term_ratio_code))) else $error("termination level wrong");
  charge_forces_adc_a: assert property (
    charge_current_on |-> adc_enable && adc_periodic && battery_voltage_channel_enable) else $error("adc not forced");
  pre_to_cc_a: assert property (
    pre_done_s |=> !precharge_mode && charge_current_on) else $error("precharge did not move to fast charge");
  cc_to_cv_a: assert property (
    cc_done_s |=> const_voltage_mode) else $error("constant current did not move to constant voltage");
  cv_finish_a: assert property (
    cv_done_s |=> irq && !const_voltage_mode && !charge_current_on && !adc_enable) else $error("no clean finish");
  range_irq_a: assert property (
    adapter_in_range != adapter_path_gate |=> irq) else $error("adapter range change without irq");
  irq_sticky_a: assert property (
    irq && !temp_out_of_range_in && !$past(temp_out_of_range_in)
      && !(reg_wr && reg_addr == ADDR_CONTROL && !reg_wdata[CTL_IRQ]) |=> irq) else $error("irq dropped alone");
  status_read_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[ST_VEXT] == $past(adapter_path_gate)
      && reg_rdata[ST_PRECHG] == $past(precharge_mode)) else $error("status read wrong");
  unmapped_read_a: assert property (
    reg_rd && reg_addr != ADDR_CONTROL && reg_addr != ADDR_STATUS |=> reg_rdata == UNMAPPED_READ)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// *** dv/chgctl_batt_model.sv ***
// battery pack and sense comparators answering the charger
`default_nettype none
module chgctl_batt_model #(
  parameter int PRE_CYC = 30,
  parameter int CC_CYC = 40,
  parameter int CV_CYC = 20
) (
  input wire logic mclk,
  input wire logic new_pack,
  input wire logic dead_cell,
  input wire logic charge_current_on,
  input wire logic const_voltage_mode,
  output logic batt_at_precharge_level,
  output logic batt_at_regulation,
  output logic current_below_term
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // pack charges only while current flows
  always @(posedge mclk) begin
    if (new_pack) begin
      cnt <= 0;
    end else if (charge_current_on) begin
      cnt <= cnt + 1;
    end
  end
  assign batt_at_precharge_level = cnt >= PRE_CYC;
  assign batt_at_regulation = !dead_cell && cnt >= PRE_CYC + CC_CYC;
  assign current_below_term = const_voltage_mode && cnt >= PRE_CYC + CC_CYC + CV_CYC;
endmodule
`default_nettype wire

// *** dv/chgctl_top_tb.sv ***
// self-checking bench for the charger control block
`default_nettype none
module chgctl_top_tb import chgctl_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 10;
  logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, new_pack = 1, dead_cell = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv, adc_bus;
  logic adapter_in_range = 0, batt_above_nocharge_level = 0, batt_voltage_fault = 0, temp_out_of_range_in = 0;
  logic supply_level_42v = 0;
  logic [2:0] term_ratio_code = 3'h0, term_level_select;
  logic [15:0] precharge_limit_s = 16'h0032, cc_limit_s = 16'h0000, total_limit_s = 16'h0000;
  logic adc_enable, adc_periodic, battery_voltage_channel_enable, temperature_channel_enable, aux_input1_enable;
  logic aux_input2_enable, charge_current_on, precharge_mode, const_voltage_mode, charger_gate;
  logic adapter_path_gate, battery_path_gate, supply_divider_setting, irq;
  logic batt_at_precharge_level, batt_at_regulation, current_below_term;
  int mismatches = 0, tests_run = 0, n;
  assign adc_bus = {2'h0, adc_enable, adc_periodic, battery_voltage_channel_enable, temperature_channel_enable,
    aux_input1_enable, aux_input2_enable};
  always #4 mclk = ~mclk;
  chgctl_top #(.SECOND_CYCLES(SC)) chgctl_top_i (.*);
  chgctl_batt_model chgctl_batt_model_i (.*);
  function automatic logic [7:0] ctl_exp(input logic [7:0] d);
    return d & 8'h7e;
  endfunction
  function automatic logic [2:0] term_exp(input logic [2:0] c);
    return (c > TERM_RATIO_MAX) ? TERM_RATIO_MAX : c;
  endfunction
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input string what, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    cyc(1);
    chk(what, reg_rdata, exp);
  endtask
  task automatic wait_for(input int k, input int lim);
    n = 0;
    while (!(k == 0 ? precharge_mode : k == 1 ? const_voltage_mode : irq) && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      chk("wait bound", 8'h01, 8'h00);
      give_verdict();
    end
  endtask
  task automatic fresh_pack();
    new_pack = 1;
    cyc(1);
    new_pack = 0;
  endtask
  initial begin
    void'($urandom(18326));
    cyc(3);
    sys_rst = 0;
    new_pack = 0;
    rd(ADDR_CONTROL, "control reset", CONTROL_RESET);
    rd(ADDR_STATUS, "status reset", STATUS_RESET);
    chk("gates off", {5'h00, charger_gate, adapter_path_gate, battery_path_gate}, 8'h05);
    adapter_in_range = 1;
    for (int i = 0; i < 2; i++) begin
      supply_level_42v = i[0];
      cyc(2);
      chk("divider", {7'h00, supply_divider_setting}, {7'h00, i[0]});
    end
    chk("gates on", {5'h00, charger_gate, adapter_path_gate, battery_path_gate}, 8'h02);
    rd(ADDR_CONTROL, "irq on range", 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    chk("irq clear", {7'h00, irq}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      term_ratio_code = i[2:0];
      rv = 8'($urandom) & 8'h7f;
      if (i == 0) rv = 8'h7f;
      wr(ADDR_CONTROL, rv);
      chk("term level", {5'h00, term_level_select}, {5'h00, term_exp(i[2:0])});
      rd(ADDR_CONTROL, "control rw", ctl_exp(rv));
      chk("adc outputs", adc_bus, {2'h0, rv[6:1]});
    end
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, "status read only", 8'h80);
    rd(8'h1d, "unmapped", UNMAPPED_READ);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    chk("charge adc", adc_bus, 8'h3c);
    wait_for(0, 200);
    chk("wake span", {7'h00, n + 1 >= 8 * SC && n <= 9 * SC}, 8'h01);
    rd(ADDR_STATUS, "precharge", 8'h84);
    temp_out_of_range_in = 1;
    cyc(2);
    chk("temp pause", {6'h00, irq, charge_current_on}, 8'h02);
    rd(ADDR_STATUS, "temp flag", 8'ha4);
    temp_out_of_range_in = 0;
    cyc(2);
    chk("temp resume", {6'h00, irq, charge_current_on}, 8'h01);
    wait_for(2, 400);
    rd(ADDR_CONTROL, "charge done", 8'h01);
    rd(ADDR_STATUS, "term status", 8'h90);
    wr(ADDR_CONTROL, 8'h00);
    fresh_pack();
    batt_above_nocharge_level = 1;
    wr(ADDR_CONTROL, 8'h80);
    cyc(9 * SC);
    rd(ADDR_STATUS, "no charge", 8'h88);
    rd(ADDR_CONTROL, "start kept", 8'h80);
    wr(ADDR_CONTROL, 8'h00);
    batt_above_nocharge_level = 0;
    rd(ADDR_CONTROL, "host stop", 8'h00);
    fresh_pack();
    dead_cell = 1;
    cc_limit_s = 16'h0002;
    wr(ADDR_CONTROL, 8'hfe);
    wait_for(2, 600);
    rd(ADDR_STATUS, "cc timeout", 8'hc2);
    rd(ADDR_CONTROL, "cc stop", 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    fresh_pack();
    dead_cell = 0;
    wr(ADDR_CONTROL, 8'h80);
    wait_for(0, 200);
    batt_voltage_fault = 1;
    wait_for(2, 20);
    batt_voltage_fault = 0;
    rd(ADDR_STATUS, "battery fault", 8'hc0);
    wr(ADDR_CONTROL, 8'h00);
    fresh_pack();
    precharge_limit_s = 16'h0001;
    wr(ADDR_CONTROL, 8'h80);
    wait_for(2, 200);
    rd(ADDR_STATUS, "precharge timeout", 8'hc0);
    chk("no fast charge", {6'h00, const_voltage_mode, charge_current_on}, 8'h00);
    precharge_limit_s = 16'h0032;
    wr(ADDR_CONTROL, 8'h00);
    fresh_pack();
    cc_limit_s = 16'h0000;
    total_limit_s = 16'h0005;
    wr(ADDR_CONTROL, 8'h80);
    wait_for(2, 300);
    rd(ADDR_STATUS, "total timeout", 8'h81);
    rd(ADDR_CONTROL, "total stop", 8'h01);
    total_limit_s = 16'h0000;
    wr(ADDR_CONTROL, 8'h00);
    adapter_in_range = 0;
    cyc(2);
    chk("adapter off", {4'h0, irq, charger_gate, adapter_path_gate, battery_path_gate}, 8'h0d);
    give_verdict();
  end
endmodule
bind chgctl_top chgctl_chk chgctl_chk_i (.*);
`default_nettype wire
